// File: design/dfp_pkg.sv
package dfp_pkg;

  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned BLINK_MS     = 250;
  localparam int unsigned BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int unsigned UNIT_W = 3;
  localparam int unsigned ADDR_W = 12;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_INT_STAT = 12'h008;
  localparam logic [11:0] OFF_INT_MASK = 12'h00C;

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  localparam int unsigned CTRL_PREFER_B = 0;
  localparam int unsigned CTRL_W        = 1;
  localparam logic [0:0]  CTRL_RESET    = 1'h0;

  // ----------------------------------------
  // interrupt event bits
  // ----------------------------------------
  localparam int unsigned EV_READY_UP   = 0;
  localparam int unsigned EV_READY_DOWN = 1;
  localparam int unsigned EV_FAULT      = 2;
  localparam int unsigned EV_WR_REFUSED = 3;
  localparam int unsigned EV_SELF_TEST  = 4;
  localparam int unsigned EV_W          = 5;
  localparam logic [4:0]  INT_RESET     = 5'h00;

  // ----------------------------------------
  // drive states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_STOPPED,
    ST_SPINUP,
    ST_INIT,
    ST_READY,
    ST_SEEK,
    ST_DRAIN,
    ST_SPINDOWN,
    ST_FAULT
  } dfp_state_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic run;
    logic write_inhibit_switch;
    logic port_a;
    logic port_b;
  } dfp_switch_t;

  typedef struct packed {
    logic run;
    logic fault;
    logic ready;
    logic write_inhibit;
    logic port_a;
    logic port_b;
  } dfp_lamp_t;

  typedef struct packed {
    logic at_speed;
    logic stopped;
    logic init_done;
    logic init_pass;
    logic fault;
  } dfp_mech_t;

endpackage

// File: design/dfp_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// two-stage synchroniser
// ----------------------------------------
module dfp_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// File: design/dfp_blink.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// lamp blinker, toggles every half period
// ----------------------------------------
module dfp_blink #(
  parameter int unsigned HALF = dfp_pkg::BLINK_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  output logic      phase_ff
);

  logic [31:0] cnt_ff;

  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_ff   <= 32'h0000_0000;
      phase_ff <= 1'b0;
    end else if (cnt_ff >= HALF - 1) begin
      cnt_ff   <= 32'h0000_0000;
      phase_ff <= ~phase_ff;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

// File: design/dfp_panel.sv
`timescale 1ns/10ps
`default_nettype none
module dfp_panel #(
  parameter int unsigned BLINK_HALF = dfp_pkg::BLINK_CYCLES
) (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dfp_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  output logic                              irq,
  // panel pins
  input  wire dfp_pkg::dfp_switch_t         switches,
  input  wire logic [dfp_pkg::UNIT_W-1:0]   unit_plug,
  output dfp_pkg::dfp_lamp_t                lamps,
  // controller side pins
  input  wire logic [dfp_pkg::UNIT_W-1:0]   drive_select,
  input  wire logic                         port_a_access,
  input  wire logic                         port_b_access,
  input  wire logic                         write_cmd,
  input  wire logic                         seek_cmd,
  output logic                              selected,
  output logic                              drive_ready,
  output logic                              port_a_online,
  output logic                              port_b_online,
  output logic                              write_accept,
  output logic                              write_refuse,
  // drive mechanics
  input  wire dfp_pkg::dfp_mech_t           mech,
  input  wire logic                         seek_done,
  input  wire logic                         ops_pending,
  output logic                              spindle_on,
  output logic                              seek_start,
  output logic                              diag_enable
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  dfp_pkg::dfp_switch_t            sw;
  logic [dfp_pkg::UNIT_W-1:0]      unit_code;
  logic [dfp_pkg::UNIT_W-1:0]      sel_lines;
  logic                            acc_a;
  logic                            acc_b;
  logic                            wr_cmd;
  logic                            sk_cmd;

  dfp_sync #(.W(4)) u_sync_sw (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (switches),
    .q       (sw)
  );

  dfp_sync #(.W(2 * dfp_pkg::UNIT_W + 4)) u_sync_ctl (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({unit_plug, drive_select, port_a_access, port_b_access,
               write_cmd, seek_cmd}),
    .q       ({unit_code, sel_lines, acc_a, acc_b, wr_cmd, sk_cmd})
  );

  // ----------------------------------------
  // registers and shared terms
  // ----------------------------------------
  dfp_pkg::dfp_state_t             state_ff;
  dfp_pkg::dfp_state_t             nxt_state;
  logic [dfp_pkg::CTRL_W-1:0]      ctrl_ff;
  logic [dfp_pkg::EV_W-1:0]        int_stat_ff;
  logic [dfp_pkg::EV_W-1:0]        int_mask_ff;
  logic [dfp_pkg::EV_W-1:0]        events;
  logic                            active_a_ff;
  logic                            active_b_ff;
  logic                            ready_q;
  logic                            ready_prev_ff;
  logic                            self_test;
  logic                            blink;
  logic                            sel_hit;
  logic                            online;
  logic                            apb_wr;
  logic                            apb_rd;

  assign self_test = !sw.port_a && !sw.port_b;
  assign sel_hit   = (sel_lines == unit_code);
  assign online    = active_a_ff || active_b_ff;
  assign apb_wr    = psel && penable && !pready && pwrite;
  assign apb_rd    = psel && penable && !pready && !pwrite;

  function automatic logic hit(input logic [dfp_pkg::ADDR_W-1:0] a,
                               input logic [11:0] off);
    hit = (a == off);
  endfunction

  dfp_blink #(.HALF(BLINK_HALF)) u_blink (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .run      (self_test),
    .phase_ff (blink)
  );

  // ----------------------------------------
  // spindle state machine
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      dfp_pkg::ST_STOPPED: begin
        if (sw.run) begin
          nxt_state = dfp_pkg::ST_SPINUP;
        end
      end
      dfp_pkg::ST_SPINUP: begin
        if (mech.fault) begin
          nxt_state = dfp_pkg::ST_FAULT;
        end else if (!sw.run) begin
          nxt_state = dfp_pkg::ST_SPINDOWN;
        end else if (mech.at_speed) begin
          nxt_state = dfp_pkg::ST_INIT;
        end
      end
      dfp_pkg::ST_INIT: begin
        if (mech.fault) begin
          nxt_state = dfp_pkg::ST_FAULT;
        end else if (mech.init_done) begin
          nxt_state = mech.init_pass ? dfp_pkg::ST_READY
                                     : dfp_pkg::ST_FAULT;
        end
      end
      dfp_pkg::ST_READY: begin
        if (mech.fault) begin
          nxt_state = dfp_pkg::ST_FAULT;
        end else if (!sw.run) begin
          nxt_state = (online || ops_pending) ? dfp_pkg::ST_DRAIN
                                              : dfp_pkg::ST_SPINDOWN;
        end else if (sk_cmd && sel_hit && online) begin
          nxt_state = dfp_pkg::ST_SEEK;
        end
      end
      dfp_pkg::ST_SEEK: begin
        if (mech.fault) begin
          nxt_state = dfp_pkg::ST_FAULT;
        end else if (seek_done) begin
          nxt_state = sw.run ? dfp_pkg::ST_READY
                             : dfp_pkg::ST_DRAIN;
        end
      end
      dfp_pkg::ST_DRAIN: begin
        if (mech.fault) begin
          nxt_state = dfp_pkg::ST_FAULT;
        end else if (!ops_pending) begin
          nxt_state = dfp_pkg::ST_SPINDOWN;
        end
      end
      dfp_pkg::ST_SPINDOWN: begin
        if (mech.stopped) begin
          nxt_state = dfp_pkg::ST_STOPPED;
        end
      end
      dfp_pkg::ST_FAULT: begin
        if (!sw.run) begin
          nxt_state = dfp_pkg::ST_SPINDOWN;
        end
      end
      default: begin
        nxt_state = dfp_pkg::ST_STOPPED;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= dfp_pkg::ST_STOPPED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // ready qualification
  // ----------------------------------------
  assign ready_q = (nxt_state == dfp_pkg::ST_READY)
                   && sw.run && !mech.stopped
                   && !self_test && !mech.fault;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_ready   <= 1'b0;
      ready_prev_ff <= 1'b0;
    end else begin
      drive_ready   <= ready_q;
      ready_prev_ff <= drive_ready;
    end
  end

  // ----------------------------------------
  // port arbitration
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_a_ff <= 1'b0;
      active_b_ff <= 1'b0;
    end else if (active_a_ff) begin
      active_a_ff <= sw.port_a && acc_a;
    end else if (active_b_ff) begin
      active_b_ff <= sw.port_b && acc_b;
    end else if (sw.port_a && acc_a && sw.port_b && acc_b) begin
      active_a_ff <= !ctrl_ff[dfp_pkg::CTRL_PREFER_B];
      active_b_ff <= ctrl_ff[dfp_pkg::CTRL_PREFER_B];
    end else begin
      active_a_ff <= sw.port_a && acc_a;
      active_b_ff <= sw.port_b && acc_b;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_a_online <= 1'b0;
      port_b_online <= 1'b0;
      selected      <= 1'b0;
      diag_enable   <= 1'b0;
    end else begin
      port_a_online <= active_a_ff;
      port_b_online <= active_b_ff;
      selected      <= sel_hit;
      diag_enable   <= self_test;
    end
  end

  // ----------------------------------------
  // write and seek commands
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_accept <= 1'b0;
      write_refuse <= 1'b0;
      seek_start   <= 1'b0;
    end else begin
      write_accept <= wr_cmd && sel_hit && online && drive_ready
                      && !sw.write_inhibit_switch;
      write_refuse <= wr_cmd && sel_hit && online
                      && sw.write_inhibit_switch;
      seek_start   <= (state_ff == dfp_pkg::ST_READY)
                      && (nxt_state == dfp_pkg::ST_SEEK);
    end
  end

  // ----------------------------------------
  // lamps and spindle
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lamps      <= '0;
      spindle_on <= 1'b0;
    end else begin
      lamps.run           <= (nxt_state != dfp_pkg::ST_STOPPED);
      lamps.fault         <= (nxt_state == dfp_pkg::ST_FAULT);
      lamps.ready         <= self_test ? blink : ready_q;
      lamps.write_inhibit <= sw.write_inhibit_switch;
      lamps.port_a        <= active_a_ff;
      lamps.port_b        <= active_b_ff;
      spindle_on          <= (sw.run && nxt_state != dfp_pkg::ST_SPINDOWN)
                             || (nxt_state == dfp_pkg::ST_DRAIN);
    end
  end

  // ----------------------------------------
  // interrupt events
  // ----------------------------------------
  always_comb begin
    events = '0;
    events[dfp_pkg::EV_READY_UP]   = drive_ready && !ready_prev_ff;
    events[dfp_pkg::EV_READY_DOWN] = !drive_ready && ready_prev_ff;
    events[dfp_pkg::EV_FAULT]      = (nxt_state == dfp_pkg::ST_FAULT)
                                     && (state_ff != dfp_pkg::ST_FAULT);
    events[dfp_pkg::EV_WR_REFUSED] = write_refuse;
    events[dfp_pkg::EV_SELF_TEST]  = self_test && !diag_enable;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      int_stat_ff <= dfp_pkg::INT_RESET;
    end else if (apb_wr && hit(paddr, dfp_pkg::OFF_INT_STAT)) begin
      int_stat_ff <= (int_stat_ff & ~pwdata[dfp_pkg::EV_W-1:0]) | events;
    end else begin
      int_stat_ff <= int_stat_ff | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_ff & int_mask_ff);
    end
  end

  // ----------------------------------------
  // apb register file
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff     <= dfp_pkg::CTRL_RESET;
      int_mask_ff <= dfp_pkg::INT_RESET;
    end else if (apb_wr) begin
      if (hit(paddr, dfp_pkg::OFF_CTRL)) begin
        ctrl_ff <= pwdata[dfp_pkg::CTRL_W-1:0];
      end
      if (hit(paddr, dfp_pkg::OFF_INT_MASK)) begin
        int_mask_ff <= pwdata[dfp_pkg::EV_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_wr || apb_rd;
      pslverr <= (apb_wr || apb_rd)
                 && !hit(paddr, dfp_pkg::OFF_CTRL)
                 && !hit(paddr, dfp_pkg::OFF_STATUS)
                 && !hit(paddr, dfp_pkg::OFF_INT_STAT)
                 && !hit(paddr, dfp_pkg::OFF_INT_MASK);
      prdata  <= 32'h0000_0000;
      if (apb_rd) begin
        if (hit(paddr, dfp_pkg::OFF_CTRL)) begin
          prdata <= {31'h0000_0000, ctrl_ff};
        end
        if (hit(paddr, dfp_pkg::OFF_STATUS)) begin
          prdata <= {19'h0_0000, unit_code, 1'b0, state_ff, lamps};
        end
        if (hit(paddr, dfp_pkg::OFF_INT_STAT)) begin
          prdata <= {27'h000_0000, int_stat_ff};
        end
        if (hit(paddr, dfp_pkg::OFF_INT_MASK)) begin
          prdata <= {27'h000_0000, int_mask_ff};
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: sim/dfp_panel_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// panel checker
// ----------------------------------------
module dfp_panel_monitor (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst,
  // apb
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  // panel
  input wire dfp_pkg::dfp_switch_t switches,
  input wire logic [2:0]           unit_plug,
  input wire dfp_pkg::dfp_lamp_t   lamps,
  // controller side
  input wire logic [2:0]           drive_select,
  input wire logic                 selected,
  input wire logic                 drive_ready,
  input wire logic                 port_a_online,
  input wire logic                 port_b_online,
  input wire logic                 write_accept,
  input wire logic                 seek_start,
  input wire logic                 diag_enable
);
  default clocking dfp_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_SEL: assert property (
    $stable({drive_select, unit_plug}) [*5]
      |-> selected == (drive_select == unit_plug))
    else $error("select does not follow unit match");
  AST_PREADY: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not one cycle after take");
  AST_QUAL: assert property (
    drive_ready |-> lamps.run)
    else $error("ready without run lamp");
  AST_SEEK: assert property (
    seek_start |-> ##2 !drive_ready)
    else $error("ready during seek");
  AST_DIAG_ON: assert property (
    (!switches.port_a && !switches.port_b) [*5] |-> diag_enable)
    else $error("diagnostics not enabled with ports out");
  AST_DIAG_NRDY: assert property (
    diag_enable [*2] |-> !drive_ready)
    else $error("ready during self test");
  AST_WI_LAMP: assert property (
    $stable(switches.write_inhibit_switch) [*5]
      |-> lamps.write_inhibit == switches.write_inhibit_switch)
    else $error("inhibit lamp does not follow switch");
  AST_WR_INH: assert property (
    lamps.write_inhibit |-> !write_accept)
    else $error("write accepted while inhibited");
  AST_ONE_PORT: assert property (
    !(port_a_online && port_b_online))
    else $error("both ports online");
  AST_A_OFF: assert property (
    (!switches.port_a) [*5] |-> !port_a_online)
    else $error("port a online with switch out");
endmodule

bind dfp_panel dfp_panel_monitor i_dfp_panel_monitor (
  .sys_clk, .rst, .psel, .penable, .pready, .switches, .unit_plug,
  .lamps, .drive_select, .selected, .drive_ready, .port_a_online,
  .port_b_online, .write_accept, .seek_start, .diag_enable
);
`default_nettype wire

// File: sim/dfp_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// controller ports and drive mechanics
// ----------------------------------------
module dfp_ctrl_model (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // drive side
  input  wire logic         spindle_on,
  input  wire logic         seek_start,
  output dfp_pkg::dfp_mech_t mech,
  output logic              seek_done,
  output logic              port_a_access,
  output logic              port_b_access,
  // scenario control
  input  wire logic         init_ok,
  input  wire logic         slow,
  input  wire logic [1:0]   use_port
);
  logic [4:0] spin_ff;
  logic [3:0] seek_ff;

  // spindle speed ramps up and down
  always_ff @(posedge sys_clk) begin
    if (rst)
      spin_ff <= 5'h0;
    else if (spindle_on && spin_ff != 5'h1e)
      spin_ff <= spin_ff + 5'h1;
    else if (!spindle_on && spin_ff != 5'h0)
      spin_ff <= spin_ff - 5'h1;
  end

  // seek answers promptly or slowly
  always_ff @(posedge sys_clk) begin
    if (rst)
      seek_ff <= 4'h0;
    else if (seek_start)
      seek_ff <= slow ? 4'hf : 4'h4;
    else if (seek_ff != 4'h0)
      seek_ff <= seek_ff - 4'h1;
  end

  assign seek_done = (seek_ff == 4'h1);

  always_comb begin
    mech           = '0;
    mech.at_speed  = spin_ff >= 5'h14;
    mech.init_done = spin_ff >= 5'h1a;
    mech.init_pass = init_ok;
    mech.stopped   = !spindle_on && spin_ff == 5'h0;
  end

  // one port at a time, only when asked
  assign port_a_access = (use_port == 2'h1);
  assign port_b_access = (use_port == 2'h2);
endmodule
`default_nettype wire

// File: sim/dfp_panel_test.sv
`timescale 1ns/10ps
`default_nettype none
module dfp_panel_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                 sys_clk, rst, psel, penable, pwrite, pready;
  logic                 pslverr, irq, selected, drive_ready, er;
  logic                 port_a_online, port_b_online, write_accept;
  logic                 write_refuse, spindle_on, seek_start, diag_enable;
  logic                 write_cmd, seek_cmd, seek_done, ops_pending;
  logic                 port_a_access, port_b_access, init_ok, slow;
  logic [1:0]           use_port;
  logic [2:0]           unit_plug, drive_select;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rd;
  int                   num_errors, total_checks;
  dfp_pkg::dfp_switch_t switches;
  dfp_pkg::dfp_lamp_t   lamps;
  dfp_pkg::dfp_mech_t   mech;

  dfp_panel #(.BLINK_HALF(4)) i_dfp_panel (
    .sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq, .switches, .unit_plug, .lamps, .drive_select,
    .port_a_access, .port_b_access, .write_cmd, .seek_cmd, .selected,
    .drive_ready, .port_a_online, .port_b_online, .write_accept,
    .write_refuse, .mech, .seek_done, .ops_pending, .spindle_on,
    .seek_start, .diag_enable
  );

  dfp_ctrl_model i_dfp_ctrl_model (
    .sys_clk, .rst, .spindle_on, .seek_start, .mech, .seek_done,
    .port_a_access, .port_b_access, .init_ok, .slow, .use_port
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    cyc(1);
    penable <= 1'h1;
    cyc(1);
    while (pready !== 1'h1)
      cyc(1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    cyc(1);
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    cyc(4);
    apb(1'h0, dfp_pkg::OFF_STATUS, 32'h0);
    chk(rd[12:10], 32'h5);
    chk(selected, 32'h1);
    drive_select <= 3'h2;
    cyc(5);
    chk(selected, 32'h0);
    drive_select <= 3'h5;
    apb(1'h0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
    apb(1'h1, dfp_pkg::OFF_CTRL, 32'h1);
    apb(1'h0, dfp_pkg::OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'h0, dfp_pkg::OFF_INT_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, dfp_pkg::OFF_INT_STAT, 32'h0);
    chk(rd[4], 32'h1);
    apb(1'h1, dfp_pkg::OFF_INT_STAT, 32'h1f);
    apb(1'h1, dfp_pkg::OFF_CTRL, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_spinup();
    apb(1'h1, dfp_pkg::OFF_INT_MASK, 32'h1f);
    use_port <= 2'h1;
    switches.run <= 1'h1;
    switches.port_a <= 1'h1;
    cyc(6);
    chk(lamps.run, 32'h1);
    chk(drive_ready, 32'h0);
    for (int i = 0; i < 100 && drive_ready !== 1'h1; i++)
      cyc(1);
    chk(drive_ready, 32'h1);
    chk(lamps.ready, 32'h1);
    chk(port_a_online, 32'h1);
    chk(lamps.port_a, 32'h1);
    apb(1'h0, dfp_pkg::OFF_INT_STAT, 32'h0);
    chk(rd[0], 32'h1);
    chk(irq, 32'h1);
    apb(1'h1, dfp_pkg::OFF_INT_STAT, 32'h1f);
    cyc(2);
    chk(irq, 32'h0);
    $display("test spinup done");
  endtask

  task automatic t_seek();
    slow <= 1'h1;
    seek_cmd <= 1'h1;
    for (int i = 0; i < 20 && seek_start !== 1'h1; i++)
      cyc(1);
    seek_cmd <= 1'h0;
    cyc(3);
    chk(drive_ready, 32'h0);
    cyc(6);
    chk(drive_ready, 32'h0);
    for (int i = 0; i < 40 && drive_ready !== 1'h1; i++)
      cyc(1);
    chk(drive_ready, 32'h1);
    $display("test seek done");
  endtask

  task automatic t_write();
    write_cmd <= 1'h1;
    cyc(5);
    chk(write_accept, 32'h1);
    chk(write_refuse, 32'h0);
    switches.write_inhibit_switch <= 1'h1;
    cyc(5);
    chk(lamps.write_inhibit, 32'h1);
    chk(write_refuse, 32'h1);
    chk(write_accept, 32'h0);
    write_cmd <= 1'h0;
    apb(1'h0, dfp_pkg::OFF_INT_STAT, 32'h0);
    chk(rd[3], 32'h1);
    apb(1'h1, dfp_pkg::OFF_INT_STAT, 32'h1f);
    switches.write_inhibit_switch <= 1'h0;
    cyc(5);
    chk(lamps.write_inhibit, 32'h0);
    $display("test write done");
  endtask

  task automatic t_ports();
    switches.port_b <= 1'h1;
    use_port <= 2'h0;
    cyc(5);
    chk(port_a_online, 32'h0);
    use_port <= 2'h2;
    cyc(5);
    chk(port_b_online, 32'h1);
    chk(port_a_online, 32'h0);
    chk(lamps.port_b, 32'h1);
    chk(lamps.port_a, 32'h0);
    use_port <= 2'h1;
    switches.port_b <= 1'h0;
    cyc(6);
    chk(port_a_online, 32'h1);
    $display("test ports done");
  endtask

  task automatic t_selftest();
    int   n;
    logic p;
    n = 0;
    switches.port_a <= 1'h0;
    cyc(5);
    chk(drive_ready, 32'h0);
    chk(diag_enable, 32'h1);
    p = lamps.ready;
    repeat (20) begin
      cyc(1);
      if (lamps.ready !== p)
        n++;
      p = lamps.ready;
    end
    chk(32'(n > 3), 32'h1);
    chk(drive_ready, 32'h0);
    switches.port_a <= 1'h1;
    cyc(5);
    chk(diag_enable, 32'h0);
    for (int i = 0; i < 40 && drive_ready !== 1'h1; i++)
      cyc(1);
    $display("test selftest done");
  endtask

  task automatic t_spindown();
    ops_pending <= 1'h1;
    switches.run <= 1'h0;
    cyc(12);
    chk(spindle_on, 32'h1);
    chk(lamps.run, 32'h1);
    ops_pending <= 1'h0;
    for (int i = 0; i < 100 && lamps.run !== 1'h0; i++)
      cyc(1);
    chk(lamps.run, 32'h0);
    chk(drive_ready, 32'h0);
    chk(spindle_on, 32'h0);
    $display("test spindown done");
  endtask

  task automatic t_fault();
    init_ok <= 1'h0;
    switches.run <= 1'h1;
    for (int i = 0; i < 100 && lamps.fault !== 1'h1; i++)
      cyc(1);
    chk(lamps.fault, 32'h1);
    chk(drive_ready, 32'h0);
    chk(lamps.ready, 32'h0);
    apb(1'h0, dfp_pkg::OFF_INT_STAT, 32'h0);
    chk(rd[2], 32'h1);
    switches.run <= 1'h0;
    cyc(5);
    $display("test fault done");
  endtask

  // ----------------------------------------
  // clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    switches = '0;
    unit_plug = 3'h5;
    drive_select = 3'h5;
    write_cmd = 1'h0;
    seek_cmd = 1'h0;
    ops_pending = 1'h0;
    init_ok = 1'h1;
    slow = 1'h0;
    use_port = 2'h0;
    num_errors = 0;
    total_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    t_regs();
    t_spinup();
    t_seek();
    t_write();
    t_ports();
    t_selftest();
    t_spindown();
    t_fault();
    test_done();
  end

  // all scenarios need well under a thousand cycles
  initial begin
    repeat (6000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
